/* pkg/obs_pkg.sv */
// constants and types shared by the operand b source selector
package obs_pkg;

  // number of programmable outputs and field widths
  localparam int NUM_OUT = 4;
  localparam int SEL_W = 7;
  localparam int MODE_W = 3;
  localparam int NUM_BOOL = 80;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SPEED_W = 16;

  // register byte offsets; one 32-bit word per register
  localparam logic [7:0] OFS_MODE_BASE = 8'h00;
  localparam logic [7:0] OFS_SEL_BASE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] REG_STRIDE = 8'h04;

  // status register field positions
  localparam int ST_BOOL_LSB = 0;
  localparam int ST_TEST_LSB = 4;
  localparam int ST_KWH_BIT = 8;
  localparam int ST_FWD_BIT = 9;
  localparam int ST_REV_BIT = 10;

  // values after reset
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
  localparam logic [SEL_W-1:0] SEL_RST = 7'h00;

  // output operating modes
  typedef enum logic [MODE_W-1:0] {
    OBS_MODE_OFF = 3'b000,
    OBS_MODE_DIGITAL = 3'b001,
    OBS_MODE_DOUBLE = 3'b010,
    OBS_MODE_ANALOG = 3'b011,
    OBS_MODE_BRAKE = 3'b100,
    OBS_MODE_ABS_BRAKE = 3'b101,
    OBS_MODE_ABS_LIFT = 3'b110,
    OBS_MODE_PWM = 3'b111
  } obs_mode_e;

  // source codes that the checks refer to
  localparam logic [SEL_W-1:0] SRC_DISABLED = 7'h00;
  localparam logic [SEL_W-1:0] SRC_FWD_RUN = 7'h05;
  localparam logic [SEL_W-1:0] SRC_REV_RUN = 7'h06;
  localparam logic [SEL_W-1:0] SRC_LIMITING = 7'h09;
  localparam logic [SEL_W-1:0] SRC_INPUT_ONE = 7'h0d;
  localparam logic [SEL_W-1:0] SRC_ENABLE = 7'h15;
  localparam logic [SEL_W-1:0] SRC_RESERVED_A = 7'h43;
  localparam logic [SEL_W-1:0] SRC_KWH = 7'h4a;

  // speed dead band in tenths of rpm (0.5 rpm)
  localparam logic signed [SPEED_W-1:0] SPEED_DEADBAND_DRPM = 16'sh0005;

  // energy pulse length
  localparam int KWH_PULSE_MS = 500;
  localparam longint CLK_FREQ_HZ = 100_000_000;
  localparam int KWH_PULSE_CYC = int'((64'(KWH_PULSE_MS) * CLK_FREQ_HZ) / 64'd1000);

endpackage

/* hw/obs_b_slice.sv */
// one operand b multiplexer slice with registered result
`timescale 1ns/10ps
module obs_b_slice #(
  parameter int NUM_SRC = obs_pkg::NUM_BOOL,
  parameter int SEL_W = obs_pkg::SEL_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_SRC-1:0] src_vec,
  input wire logic [SEL_W-1:0] sel_code,
  input wire logic b_active,
  output logic b_bool_reg,
  output logic b_test_en_reg
);

  logic b_bool_next;
  logic b_test_en_next;
  wire is_bool;
  wire picked;

  // codes below the boolean count pick a flag, the rest are analog
  assign is_bool = int'(sel_code) < NUM_SRC;
  assign picked = is_bool ? src_vec[sel_code] : 1'b0;
  // boolean source bypasses the comparison, analog one enables it
  assign b_bool_next = b_active & picked;
  assign b_test_en_next = b_active & ~is_bool;

  // result register, cleared on reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      b_bool_reg <= 1'b0;
      b_test_en_reg <= 1'b0;
    end
    else
    begin
      b_bool_reg <= b_bool_next;
      b_test_en_reg <= b_test_en_next;
    end
  end

endmodule

/* hw/obs_pulse_stretch.sv */
// retriggerable pulse stretcher of fixed length
`timescale 1ns/10ps
module obs_pulse_stretch #(
  parameter int LEN = obs_pkg::KWH_PULSE_CYC,
  parameter int CNT_W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic trig,
  output logic pulse_reg
);

  localparam logic [CNT_W-1:0] LEN_C = CNT_W'(LEN);
  localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic pulse_next;

  // a trigger reloads, otherwise count down to zero
  assign cnt_next = trig ? LEN_C : ((cnt_reg != '0) ? cnt_reg - ONE_C : '0);
  assign pulse_next = cnt_next != '0;

  // counter and output flop
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

endmodule

/* hw/obs_selector_b.sv */
// operand b source selector for four programmable outputs
// Operation
// - boolean source skips test b comparison
// - select locked in modes off, digital and analog
// - codes 1-4 give run and alarm status
// - code 5 true above +0.5 rpm
// - code 6 true below -0.5 rpm
// - codes 7-9 give limiting, motor, generator, either
// - codes 13-20 are input remote OR pin
// - codes 21-22 are enables remote AND pin
// - codes 23-31 are delayed inputs and enable
// - codes 34-37 are fieldbus command bits
// - codes 42-49 are auxiliary expansion inputs
// - codes 50-53 are delayed logic blocks
// - codes 54-55 are maintenance intervals elapsed
// - codes 56-59 feed back delayed outputs
// - code 65 ORs four warnings
// - code 66 flags deceleration to stop
// - code 74 pulses 500 ms per kWh
// - code 10 gives precharge relay ok
// - codes 11-12 give regulator saturation limits
// - select reachable only in modes 2 and 4 to 7
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module obs_selector_b #(
  parameter int NUM_OUT = obs_pkg::NUM_OUT,
  parameter int KWH_PULSE_CYCLES = obs_pkg::KWH_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [obs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [obs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [obs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic drive_running,
  input wire logic drive_alarm,
  input wire logic signed [obs_pkg::SPEED_W-1:0] speed_drpm,
  input wire logic limit_motoring,
  input wire logic limit_generating,
  input wire logic precharge_ok,
  input wire logic pid_out_max,
  input wire logic pid_out_min,
  input wire logic [7:0] multifunction_input_remote,
  input wire logic [7:0] multifunction_input_pin,
  input wire logic enable_remote,
  input wire logic enable_pin,
  input wire logic software_enable_function_remote,
  input wire logic software_enable_function_pin,
  input wire logic [7:0] multifunction_input_delayed,
  input wire logic enable_delayed,
  input wire logic tracking_error,
  input wire logic fan_fault_warning,
  input wire logic [3:0] fieldbus_cmd,
  input wire logic fire_mode,
  input wire logic local_mode,
  input wire logic speed_ok,
  input wire logic fan_on,
  input wire logic [7:0] auxiliary_input,
  input wire logic [3:0] logic_block_delayed,
  input wire logic operation_time_maintenance_elapsed,
  input wire logic supply_time_maintenance_elapsed,
  input wire logic [3:0] programmable_output_delayed,
  input wire logic [3:0] timed_flag,
  input wire logic temp_sensor_fault_warning,
  input wire logic operation_time_over_warning,
  input wire logic supply_time_over_warning,
  input wire logic dec_to_stop,
  input wire logic accelerating,
  input wire logic decelerating,
  input wire logic kwh_tick,
  output logic [NUM_OUT-1:0] operand_b_bool,
  output logic [NUM_OUT-1:0] operand_b_test_en,
  output logic [NUM_OUT*obs_pkg::SEL_W-1:0] operand_b_code
);

  localparam int SEL_W = obs_pkg::SEL_W;
  localparam int MODE_W = obs_pkg::MODE_W;

  // operand b path is live only in modes that use a second operand
  function automatic logic b_access_ok(input logic [MODE_W-1:0] mode);
    b_access_ok = (mode != obs_pkg::OBS_MODE_OFF)
      && (mode != obs_pkg::OBS_MODE_DIGITAL)
      && (mode != obs_pkg::OBS_MODE_ANALOG);
  endfunction

  logic [MODE_W-1:0] mode_reg [NUM_OUT];
  logic [SEL_W-1:0] sel_reg [NUM_OUT];
  logic [NUM_OUT-1:0] b_act;
  logic [obs_pkg::DATA_W-1:0] rdata_next;
  logic [obs_pkg::NUM_BOOL-1:0] src_vec;
  logic kwh_pulse;

  wire fwd_run;
  wire rev_run;
  wire limiting_any;
  wire run_alarm;
  wire cumulative_warning;
  wire [7:0] input_merged;
  wire enable_merged;
  wire sw_enable_merged;
  wire [SEL_W-1:0] wdata_sel;
  wire [MODE_W-1:0] wdata_mode;

  // speed direction against the dead band
  assign fwd_run = speed_drpm > obs_pkg::SPEED_DEADBAND_DRPM;
  assign rev_run = speed_drpm < -obs_pkg::SPEED_DEADBAND_DRPM;

  // merged status terms
  assign limiting_any = limit_motoring | limit_generating;
  assign run_alarm = drive_alarm & drive_running;
  assign input_merged = multifunction_input_remote | multifunction_input_pin;
  assign enable_merged = enable_remote & enable_pin;
  assign sw_enable_merged = software_enable_function_remote
    & software_enable_function_pin;
  assign cumulative_warning = fan_fault_warning | temp_sensor_fault_warning
    | operation_time_over_warning | supply_time_over_warning;

  // energy pulse, one stretched pulse per kilowatt-hour
  obs_pulse_stretch #(
    .LEN(KWH_PULSE_CYCLES),
    .CNT_W(32)
  ) u_kwh (
    .clk(clk),
    .rst_n(rst_n),
    .trig(kwh_tick),
    .pulse_reg(kwh_pulse)
  );

  // boolean source table, highest code first; reserved codes tie low
  assign src_vec = {
    5'h00, // codes 79..75 reserved
    kwh_pulse, // code 74
    4'h0, // codes 73..70 reserved
    decelerating, // code 69
    accelerating, // code 68
    1'b0, // code 67 reserved
    dec_to_stop, // code 66
    cumulative_warning, // code 65
    temp_sensor_fault_warning, // code 64
    timed_flag, // codes 63..60
    programmable_output_delayed, // codes 59..56
    supply_time_maintenance_elapsed, // code 55
    operation_time_maintenance_elapsed, // code 54
    logic_block_delayed, // codes 53..50
    auxiliary_input, // codes 49..42
    fan_on, // code 41
    speed_ok, // code 40
    local_mode, // code 39
    fire_mode, // code 38
    fieldbus_cmd, // codes 37..34
    fan_fault_warning, // code 33
    tracking_error, // code 32
    enable_delayed, // code 31
    multifunction_input_delayed, // codes 30..23
    sw_enable_merged, // code 22
    enable_merged, // code 21
    input_merged, // codes 20..13
    pid_out_min, // code 12
    pid_out_max, // code 11
    precharge_ok, // code 10
    limiting_any, // code 9
    limit_generating, // code 8
    limit_motoring, // code 7
    rev_run, // code 6
    fwd_run, // code 5
    run_alarm, // code 4
    drive_alarm, // code 3
    ~drive_alarm, // code 2
    drive_running, // code 1
    1'b0 // code 0 always false
  };

  assign wdata_sel = reg_wdata[SEL_W-1:0];
  assign wdata_mode = reg_wdata[MODE_W-1:0];

  // per-output mode and select registers plus mux slice
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_out
      localparam logic [7:0] MODE_ADDR = obs_pkg::OFS_MODE_BASE
        + 8'(gi * obs_pkg::REG_STRIDE);
      localparam logic [7:0] SEL_ADDR = obs_pkg::OFS_SEL_BASE
        + 8'(gi * obs_pkg::REG_STRIDE);
      wire mode_hit;
      wire sel_hit;

      // select writes are dropped while the mode locks it out
      assign mode_hit = reg_wr && (reg_addr == MODE_ADDR);
      assign sel_hit = reg_wr && (reg_addr == SEL_ADDR)
        && b_access_ok(mode_reg[gi]);
      assign b_act[gi] = b_access_ok(mode_reg[gi]);

      // configuration registers
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          mode_reg[gi] <= obs_pkg::MODE_RST;
          sel_reg[gi] <= obs_pkg::SEL_RST;
        end
        else
        begin
          if (mode_hit)
            mode_reg[gi] <= wdata_mode;
          if (sel_hit)
            sel_reg[gi] <= wdata_sel;
        end
      end

      // registered multiplexer for this output
      obs_b_slice #(
        .NUM_SRC(obs_pkg::NUM_BOOL),
        .SEL_W(SEL_W)
      ) u_slice (
        .clk(clk),
        .rst_n(rst_n),
        .src_vec(src_vec),
        .sel_code(sel_reg[gi]),
        .b_active(b_act[gi]),
        .b_bool_reg(operand_b_bool[gi]),
        .b_test_en_reg(operand_b_test_en[gi])
      );

      assign operand_b_code[gi*SEL_W +: SEL_W] = sel_reg[gi];
    end
  endgenerate

  // read decode
  wire [1:0] rd_idx;
  wire rd_is_mode;
  wire rd_is_sel;
  wire rd_is_status;
  wire [obs_pkg::DATA_W-1:0] status_word;

  assign rd_idx = reg_addr[3:2];
  assign rd_is_mode = (reg_addr[7:4] == obs_pkg::OFS_MODE_BASE[7:4])
    && (reg_addr[1:0] == 2'h0);
  assign rd_is_sel = (reg_addr[7:4] == obs_pkg::OFS_SEL_BASE[7:4])
    && (reg_addr[1:0] == 2'h0);
  assign rd_is_status = reg_addr == obs_pkg::OFS_STATUS;

  // live state seen by software
  assign status_word = {
    21'h00_0000,
    rev_run,
    fwd_run,
    kwh_pulse,
    operand_b_test_en,
    operand_b_bool
  };

  // locked selects read as zero; unmapped reads as zero
  assign rdata_next = !reg_rd ? 32'h0000_0000
    : rd_is_mode ? {29'h0000_0000, mode_reg[rd_idx]}
    : (rd_is_sel && b_access_ok(mode_reg[rd_idx])) ? {25'h000_0000, sel_reg[rd_idx]}
    : rd_is_status ? status_word
    : 32'h0000_0000;

  // read data stand one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= rdata_next;
  end

  // helper counter of energy pulse length
  logic [31:0] kwh_len_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      kwh_len_reg <= 32'h0000_0000;
    else if (kwh_tick)
      kwh_len_reg <= 32'h0000_0000;
    else if (kwh_pulse)
      kwh_len_reg <= kwh_len_reg + 32'h0000_0001;
  end

  wire [7:0] sel0_addr;
  assign sel0_addr = obs_pkg::OFS_SEL_BASE;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sel_lock_a: assert property (
    reg_wr && reg_addr == sel0_addr && !b_access_ok(mode_reg[0])
    |=> sel_reg[0] == $past(sel_reg[0]))
    else $error("select changed while locked");

  sel_write_a: assert property (
    reg_wr && reg_addr == sel0_addr && b_access_ok(mode_reg[0])
    |=> sel_reg[0] == $past(wdata_sel))
    else $error("select write lost while reachable");

  bool_no_test_a: assert property (
    int'(sel_reg[0]) < obs_pkg::NUM_BOOL |=> !operand_b_test_en[0])
    else $error("test b enabled for boolean source");

  fwd_speed_a: assert property (
    sel_reg[0] == obs_pkg::SRC_FWD_RUN && b_act[0]
    |=> operand_b_bool[0] == ($past(speed_drpm) > 16'sh0005))
    else $error("forward flag wrong");

  rev_speed_a: assert property (
    sel_reg[0] == obs_pkg::SRC_REV_RUN && b_act[0]
    |=> operand_b_bool[0] == ($past(speed_drpm) < -16'sh0005))
    else $error("reverse flag wrong");

  limit_or_a: assert property (
    sel_reg[0] == obs_pkg::SRC_LIMITING && b_act[0]
    |=> operand_b_bool[0] == ($past(limit_motoring) || $past(limit_generating)))
    else $error("limiting flag wrong");

  input_or_a: assert property (
    sel_reg[0] == obs_pkg::SRC_INPUT_ONE && b_act[0]
    |=> operand_b_bool[0]
      == ($past(multifunction_input_remote[0]) || $past(multifunction_input_pin[0])))
    else $error("input merge wrong");

  enable_and_a: assert property (
    sel_reg[0] == obs_pkg::SRC_ENABLE && b_act[0]
    |=> operand_b_bool[0] == ($past(enable_remote) && $past(enable_pin)))
    else $error("enable merge wrong");

  reserved_low_a: assert property (
    sel_reg[0] == obs_pkg::SRC_RESERVED_A || sel_reg[0] == obs_pkg::SRC_DISABLED
    |=> !operand_b_bool[0])
    else $error("reserved code not false");

  kwh_length_a: assert property (
    $fell(kwh_pulse) |-> kwh_len_reg == 32'(KWH_PULSE_CYCLES))
    else $error("energy pulse length wrong");

  reset_clear_a: assert property (
    @(posedge clk) disable iff (1'b0)
    !rst_n |=> operand_b_bool == '0 && operand_b_test_en == '0)
    else $error("outputs not cleared by reset");

  status_read_a: assert property (
    reg_rd && rd_is_status |=> reg_rdata[3:0] == $past(operand_b_bool))
    else $error("status read wrong");

  fwd_seen_c: cover property (
    sel_reg[1] == obs_pkg::SRC_FWD_RUN && b_act[1] ##1 operand_b_bool[1]);
  kwh_seen_c: cover property (
    sel_reg[0] == obs_pkg::SRC_KWH && b_act[0] ##1 operand_b_bool[0]);
  analog_seen_c: cover property (operand_b_test_en[2]);
  lock_seen_c: cover property (
    reg_wr && reg_addr == sel0_addr && !b_access_ok(mode_reg[0]));

endmodule

/* tb/obs_partner.sv */
// model of the output test and logic stage fed by operand b
`timescale 1ns/10ps
module obs_partner #(
  parameter logic ANALOG_TEST = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] operand_b_bool,
  input wire logic [3:0] operand_b_test_en,
  output logic [3:0] b_result_reg
);
  // analog test result stands in for the boolean only when test b runs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      b_result_reg <= 4'h0;
    else
      b_result_reg <= (operand_b_test_en & {4{ANALOG_TEST}}) | (~operand_b_test_en & operand_b_bool);
  end
endmodule

/* tb/testbench.sv */
// self-checking bench for the operand b source selector
`timescale 1ns/10ps
module testbench;
  localparam int KWH_CYC = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic kwh_tick = 1'b0;
  logic signed [15:0] speed_drpm = 16'sh0000;
  logic [31:0] reg_rdata;
  logic [3:0] operand_b_bool, operand_b_test_en, b_result;
  logic [27:0] operand_b_code;
  logic drive_running, drive_alarm, limit_motoring, limit_generating, precharge_ok;
  logic pid_out_max, pid_out_min, enable_remote, enable_pin, enable_delayed;
  logic software_enable_function_remote, software_enable_function_pin;
  logic tracking_error, fan_fault_warning, fire_mode, local_mode, speed_ok, fan_on;
  logic operation_time_maintenance_elapsed, supply_time_maintenance_elapsed;
  logic temp_sensor_fault_warning, operation_time_over_warning, supply_time_over_warning;
  logic dec_to_stop, accelerating, decelerating;
  logic [7:0] multifunction_input_remote, multifunction_input_pin;
  logic [7:0] multifunction_input_delayed, auxiliary_input;
  logic [3:0] fieldbus_cmd, logic_block_delayed, programmable_output_delayed, timed_flag;
  int n_fail = 0;
  int total_checks = 0;

  obs_selector_b #(.KWH_PULSE_CYCLES(KWH_CYC)) dut_u (.*);
  obs_partner partner_u (.clk(clk), .rst_n(rst_n), .operand_b_bool(operand_b_bool),
    .operand_b_test_en(operand_b_test_en), .b_result_reg(b_result));

  // free-running clock
  always #5 clk = ~clk;

  task automatic summarize();
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write cycle, then an idle cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // read data is taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk);
  endtask

  // let the registered result land, then look
  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  // all boolean sources from one pattern word
  task automatic apply(input logic [73:0] p, input logic signed [15:0] s);
    speed_drpm <= s;
    {drive_running, drive_alarm, limit_motoring, limit_generating, precharge_ok, pid_out_max,
     pid_out_min, multifunction_input_remote, multifunction_input_pin, enable_remote,
     enable_pin, software_enable_function_remote, software_enable_function_pin,
     multifunction_input_delayed, enable_delayed, tracking_error, fan_fault_warning,
     fieldbus_cmd, fire_mode, local_mode, speed_ok, fan_on, auxiliary_input,
     logic_block_delayed, operation_time_maintenance_elapsed, supply_time_maintenance_elapsed,
     programmable_output_delayed, timed_flag, temp_sensor_fault_warning,
     operation_time_over_warning, supply_time_over_warning, dec_to_stop, accelerating,
     decelerating} <= p;
  endtask

  // expected value of every boolean code from the present sources
  function automatic logic [79:0] exp_vec();
    logic [79:0] v;
    v = '0;
    v[4:1] = {drive_alarm & drive_running, drive_alarm, !drive_alarm, drive_running};
    v[5] = speed_drpm > obs_pkg::SPEED_DEADBAND_DRPM;
    v[6] = speed_drpm < -obs_pkg::SPEED_DEADBAND_DRPM;
    v[9:7] = {limit_motoring | limit_generating, limit_generating, limit_motoring};
    v[12:10] = {pid_out_min, pid_out_max, precharge_ok};
    v[20:13] = multifunction_input_remote | multifunction_input_pin;
    v[21] = enable_remote & enable_pin;
    v[22] = software_enable_function_remote & software_enable_function_pin;
    v[31:23] = {enable_delayed, multifunction_input_delayed};
    v[41:32] = {fan_on, speed_ok, local_mode, fire_mode, fieldbus_cmd, fan_fault_warning,
      tracking_error};
    v[49:42] = auxiliary_input;
    v[55:50] = {supply_time_maintenance_elapsed, operation_time_maintenance_elapsed,
      logic_block_delayed};
    v[63:56] = {timed_flag, programmable_output_delayed};
    v[64] = temp_sensor_fault_warning;
    v[65] = fan_fault_warning | temp_sensor_fault_warning | operation_time_over_warning
      | supply_time_over_warning;
    v[66] = dec_to_stop;
    v[69:68] = {decelerating, accelerating};
    return v;
  endfunction

  task automatic t_reset();
    logic [31:0] d;
    #1;
    chk("bool after reset", 32'h0000_0000, 32'(operand_b_bool));
    chk("code after reset", 32'h0000_0000, 32'(operand_b_code));
    @(posedge clk);
    rd(8'h00, d);
    chk("mode0 after reset", 32'h0000_0000, d);
    rd(8'h10, d);
    chk("sel0 after reset", 32'h0000_0000, d);
    rd(8'h30, d);
    chk("unmapped read", 32'h0000_0000, d);
  endtask

  // every boolean code on output 0 under several source patterns
  task automatic t_sweep();
    logic [73:0] pat [5];
    logic signed [15:0] spd [5];
    logic [79:0] ev;
    pat = '{74'h3ff_ffff_ffff_ffff_ffff, 74'h000_0000_0000_0000_0000,
      74'h2aa_aaaa_aaaa_aaaa_aaaa, 74'h155_5555_5555_5555_5555, 74'h007_f800_0000_0000_0000};
    spd = '{16'sh0006, 16'shfffa, 16'sh0005, 16'shfffb, 16'sh0000};
    wr(8'h00, 32'h0000_0002);
    for (int k = 0; k < 5; k++)
    begin
      apply(pat[k], spd[k]);
      for (int c = 0; c < 80; c++)
      begin
        wr(8'h10, 32'(c));
        settle();
        ev = exp_vec();
        chk($sformatf("bool code %0d", c), 32'(ev[c]), 32'(operand_b_bool[0]));
        chk("test_en boolean", 32'h0000_0000, 32'(operand_b_test_en[0]));
        @(posedge clk);
      end
    end
  endtask

  // analog codes enable test b and pass through the code
  task automatic t_analog();
    logic [6:0] codes [2];
    codes = '{7'h50, 7'h7f};
    foreach (codes[i])
    begin
      wr(8'h10, 32'(codes[i]));
      settle();
      chk("test_en analog", 32'h0000_0001, 32'(operand_b_test_en[0]));
      chk("bool analog", 32'h0000_0000, 32'(operand_b_bool[0]));
      chk("code out", 32'(codes[i]), 32'(operand_b_code[6:0]));
      settle();
      chk("partner result", 32'h0000_0001, 32'(b_result[0]));
      @(posedge clk);
    end
  endtask

  // select of output 1 locked in modes 0, 1 and 3
  task automatic t_lock();
    logic [31:0] d;
    logic lk;
    logic [79:0] ev;
    apply(74'h3ff_ffff_ffff_ffff_ffff, 16'sh0006);
    for (int m = 0; m < 8; m++)
    begin
      lk = (m == 0) || (m == 1) || (m == 3);
      wr(8'h04, 32'(m));
      wr(8'h14, 32'(m + 8));
      rd(8'h14, d);
      chk($sformatf("sel1 mode %0d", m), lk ? 32'h0000_0000 : 32'(m + 8), d);
      #1;
      ev = exp_vec();
      chk("bool1 gated", lk ? 32'h0000_0000 : 32'(ev[m + 8]),
        32'(operand_b_bool[1]));
      @(posedge clk);
    end
    // live status: output 1 true, output 0 analog, forward speed
    rd(8'h20, d);
    chk("status word", 32'h0000_0212, d);
    // output 0 locked in digital mode drops a select write
    wr(8'h00, 32'h0000_0001);
    wr(8'h10, 32'h0000_0005);
    rd(8'h10, d);
    chk("sel0 locked read", 32'h0000_0000, d);
    wr(8'h00, 32'h0000_0002);
    rd(8'h10, d);
    chk("sel0 write dropped", 32'h0000_007f, d);
  endtask

  // energy pulse stretched to the set length
  task automatic t_kwh();
    int n;
    n = 0;
    apply(74'h000_0000_0000_0000_0000, 16'sh0000);
    wr(8'h10, 32'(obs_pkg::SRC_KWH));
    kwh_tick <= 1'b1;
    @(posedge clk);
    kwh_tick <= 1'b0;
    repeat (20)
    begin
      settle();
      if (operand_b_bool[0] === 1'b1)
        n++;
    end
    chk("kwh pulse cycles", 32'(KWH_CYC), 32'(n));
    @(posedge clk);
  endtask

  // watchdog
  initial
  begin
    repeat (12000) @(posedge clk);
    n_fail++;
    summarize();
  end

  // main sequence
  initial
  begin
    apply(74'h000_0000_0000_0000_0000, 16'sh0000);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_sweep();
    t_analog();
    t_lock();
    t_kwh();
    summarize();
  end
endmodule
